/* File: hdl/slr_pkg.sv */
// Purpose: constants and types of the health-monitoring log and threshold responder
// Assumes: APB register access, 32-bit data, one word per register
// Notes:   sectors are streamed a byte at a time through the data register
// Contract
// [RULE1] threshold sector: version, thirty twelve-byte entries
// [RULE2] entry: id byte 0, threshold byte 1, rest zero
// [RULE3] other attributes report threshold byte zero
// [RULE4] no defect: cylinder low 4Fh, high C2h
// [RULE5] defect: cylinder low F4h, high 2Ch
// [RULE6] host sets count and address before log read
// [RULE7] decode directory, scratch, remap, reserved log addresses
// [RULE8] directory gives version and error log sizes
// [RULE9] directory gives scratch and remap log sizes
// [RULE10] unassigned directory bytes read zero
// [RULE11] unidentified host command logs code F0h
// [RULE12] error without host command logs code FFh
// [RULE13] scratch logs return data the host wrote
// [RULE14] remap log equals remap read command data
// [RULE15] log writes only to scratch addresses
// [RULE16] host sets count and address before log write
// [RULE17] host sets count one for remap read
// [RULE18] remap sector: initial, current counts, reserved rest
// [RULE19] last threshold byte makes sector sum zero
package slr_pkg;
    localparam logic [7:0] OFS_CMD      = 8'h00;
    localparam logic [7:0] OFS_COUNT    = 8'h04;
    localparam logic [7:0] OFS_LOGADR   = 8'h08;
    localparam logic [7:0] OFS_CYL      = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_DATA     = 8'h14;
    localparam logic [7:0] OFS_THRESH   = 8'h18;
    localparam logic [7:0] OFS_REMAP    = 8'h1C;
    localparam logic [7:0] OFS_ERRCODE  = 8'h20;
    localparam logic [7:0] OFS_INT_STAT = 8'h24;
    localparam logic [7:0] OFS_INT_MASK = 8'h28;
    localparam logic [7:0] CMD_RD_THRESH = 8'hD1;
    localparam logic [7:0] CMD_STATUS    = 8'hDA;
    localparam logic [7:0] CMD_RD_LOG    = 8'hD5;
    localparam logic [7:0] CMD_WR_LOG    = 8'hD6;
    localparam logic [7:0] CMD_RD_REMAP  = 8'hE0;
    localparam logic [7:0] LOG_DIR    = 8'h00;
    localparam logic [7:0] LOG_ERRSUM = 8'h01;
    localparam logic [7:0] LOG_SCR_LO = 8'h80;
    localparam logic [7:0] LOG_SCR_HI = 8'h9F;
    localparam logic [7:0] LOG_REMAP  = 8'hA1;
    localparam logic [7:0] LOG_RSVD   = 8'hA2;
    localparam logic [7:0] CYL_LO_GOOD = 8'h4F;
    localparam logic [7:0] CYL_HI_GOOD = 8'hC2;
    localparam logic [7:0] CYL_LO_BAD  = 8'hF4;
    localparam logic [7:0] CYL_HI_BAD  = 8'h2C;
    localparam logic [15:0] THR_VERSION = 16'h0010;
    localparam logic [8:0]  THR_BASE    = 9'h002;
    localparam logic [8:0]  THR_LEN     = 9'h00C;
    localparam logic [8:0]  THR_USED    = 9'h011;
    localparam logic [8:0]  THR_REAL    = 9'h003;
    localparam logic [8:0]  SECT_LAST   = 9'h1FF;
    localparam logic [7:0]  THR_IDS [0:16] = '{8'hC4, 8'hD5, 8'hE5, 8'hCB, 8'hCC, 8'hC7,
        8'hE8, 8'h0C, 8'hF1, 8'hF2, 8'hD6, 8'hD7, 8'hC2, 8'hB8, 8'hB9, 8'hD8, 8'hD9};
    localparam logic [8:0]  DIR_VER_B    = 9'h000;
    localparam logic [8:0]  DIR_SUM_B    = 9'h002;
    localparam logic [8:0]  DIR_COMP_B   = 9'h004;
    localparam logic [8:0]  DIR_EXT_B    = 9'h006;
    localparam logic [8:0]  DIR_IDENT_B  = 9'h060;
    localparam logic [8:0]  DIR_SCR_LO_B = 9'h100;
    localparam logic [8:0]  DIR_SCR_HI_B = 9'h13F;
    localparam logic [8:0]  DIR_RSV_B    = 9'h140;
    localparam logic [8:0]  DIR_A1_B     = 9'h142;
    localparam logic [8:0]  DIR_A2_B     = 9'h144;
    localparam logic [15:0] DIR_VER      = 16'h0001;
    localparam logic [15:0] DIR_SUM      = 16'h0001;
    localparam logic [15:0] DIR_COMP     = 16'h0033;
    localparam logic [15:0] DIR_EXT      = 16'h3FFF;
    localparam logic [7:0]  DIR_IDENT    = 8'h09;
    localparam logic [7:0]  DIR_SCR      = 8'h10;
    localparam logic [7:0]  DIR_RSV      = 8'h04;
    localparam logic [7:0]  DIR_ONE      = 8'h01;
    localparam logic [8:0]  REMAP_END    = 9'h040;
    localparam logic [8:0]  ERR_CMD_B    = 9'h002;
    localparam logic [7:0]  ERR_UNKNOWN  = 8'hF0;
    localparam logic [7:0]  ERR_NO_HOST  = 8'hFF;
    localparam int          INT_DONE     = 0;
    localparam int          INT_ABORT    = 1;
    localparam int          INT_ERRLOG   = 2;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } slr_state_t;
    typedef enum logic [2:0] {
        K_THRESH  = 3'b000,
        K_DIR     = 3'b001,
        K_ERRSUM  = 3'b010,
        K_SCRATCH = 3'b011,
        K_REMAP   = 3'b100,
        K_ZERO    = 3'b101
    } slr_kind_t;
    typedef struct packed {
        logic       valid;
        logic       processed;
        logic       identified;
        logic [7:0] cmd;
    } slr_err_t;
endpackage

/* File: hdl/slr_responder.sv */
// Purpose: health-monitoring command responder behind an APB register file
// Assumes: one clock mclk at 50 MHz, synchronous active-high reset
// Notes:   zero-wait APB, prdata captured in the setup cycle
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module slr_responder #(
    parameter int SCR_SECT = 16
) (
    input  wire logic            mclk,
    input  wire logic            reset,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            defect_predicted,
    input  wire slr_pkg::slr_err_t err_event,
    output logic                 irq
);
    import slr_pkg::*;
    localparam int SW = $clog2(SCR_SECT);
    localparam int SCR_WORDS = 32 * SCR_SECT * 512;

    slr_state_t  state;
    slr_kind_t   kind;
    logic [7:0]  sec_count;
    logic [7:0]  log_adr;
    logic [7:0]  xfer_adr;
    logic [7:0]  xfer_cnt;
    logic [7:0]  sect_idx;
    logic [8:0]  ptr;
    logic [7:0]  sum;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [23:0] thresh;
    logic [4:0]  remap_sel;
    logic [15:0] remap_mem [0:31];
    logic [7:0]  scratch   [0:SCR_WORDS-1];
    logic [7:0]  err_code;
    logic        err_seen;
    logic [2:0]  int_stat;
    logic [2:0]  int_mask;
    logic [7:0]  cur_byte;
    logic [31:0] next_rdata;
    slr_kind_t   next_kind;

    // bus decode
    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire wr_acc = access & pwrite;
    wire rd_acc = access & ~pwrite;
    wire sel_cmd    = paddr == OFS_CMD;
    wire sel_count  = paddr == OFS_COUNT;
    wire sel_logadr = paddr == OFS_LOGADR;
    wire sel_cyl    = paddr == OFS_CYL;
    wire sel_status = paddr == OFS_STATUS;
    wire sel_data   = paddr == OFS_DATA;
    wire sel_thresh = paddr == OFS_THRESH;
    wire sel_remap  = paddr == OFS_REMAP;
    wire sel_err    = paddr == OFS_ERRCODE;
    wire sel_istat  = paddr == OFS_INT_STAT;
    wire sel_imask  = paddr == OFS_INT_MASK;
    wire mapped = sel_cmd | sel_count | sel_logadr | sel_cyl | sel_status | sel_data
                | sel_thresh | sel_remap | sel_err | sel_istat | sel_imask;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // command decode
    wire [7:0] cmd       = pwdata[7:0];
    wire       cmd_start = wr_acc & sel_cmd & (state == ST_IDLE);
    wire       is_scr    = (log_adr >= LOG_SCR_LO) && (log_adr <= LOG_SCR_HI); // [RULE7]
    wire       one_sect  = sec_count == 8'h01;
    wire       scr_cnt   = (sec_count != 8'h00) && (32'(sec_count) <= SCR_SECT);
    wire       log_known = (log_adr == LOG_DIR) | (log_adr == LOG_ERRSUM) | is_scr
                         | (log_adr == LOG_REMAP) | (log_adr == LOG_RSVD); // [RULE7]
    wire       log_cnt   = is_scr ? scr_cnt : one_sect;
    wire       is_status = cmd == CMD_STATUS;
    wire       go_thr    = cmd == CMD_RD_THRESH;
    wire       go_rdlog  = (cmd == CMD_RD_LOG) & log_known & log_cnt;
    wire       go_remap  = (cmd == CMD_RD_REMAP) & one_sect; // [RULE17]
    wire       go_read   = go_thr | go_rdlog | go_remap;
    wire       go_write  = (cmd == CMD_WR_LOG) & is_scr & scr_cnt; // [RULE15]
    wire       reject    = cmd_start & ~(go_read | go_write | is_status); // [RULE15]

    always_comb begin
        next_kind = K_ZERO;
        if (go_thr) begin
            next_kind = K_THRESH;
        end else if (go_remap || log_adr == LOG_REMAP) begin
            next_kind = K_REMAP; // [RULE14]
        end else if (log_adr == LOG_DIR) begin
            next_kind = K_DIR;
        end else if (log_adr == LOG_ERRSUM) begin
            next_kind = K_ERRSUM;
        end else if (is_scr) begin
            next_kind = K_SCRATCH;
        end
    end

    // data stream position
    wire data_rd   = rd_acc & sel_data & (state == ST_READ);
    wire data_wr   = wr_acc & sel_data & (state == ST_WRITE);
    wire advance   = data_rd | data_wr;
    wire last_byte = ptr == SECT_LAST;
    wire last_sect = (sect_idx + 8'h01) == xfer_cnt;
    wire xfer_end  = advance & last_byte & last_sect;
    wire done_evt  = xfer_end | (cmd_start & is_status);
    wire [8:0] rel  = ptr - THR_BASE;
    wire [8:0] ent  = rel / THR_LEN;
    wire [8:0] off  = rel % THR_LEN;
    wire       in_entries = (ptr >= THR_BASE) && (ent < THR_USED);
    wire [4:0] thr_idx = ent[4:0];
    wire [SW+13:0] scr_addr = {xfer_adr[4:0], sect_idx[SW-1:0], ptr};
    wire [15:0] remap_word = remap_mem[ptr[5:1]];
    wire [7:0] err_new = !err_event.processed ? ERR_NO_HOST
                       : !err_event.identified ? ERR_UNKNOWN : err_event.cmd;

    // byte of the sector at the current position
    always_comb begin
        cur_byte = 8'h00; // [RULE10]
        case (kind)
            K_THRESH: begin
                if (ptr == DIR_VER_B) begin
                    cur_byte = THR_VERSION[7:0]; // [RULE1]
                end else if (ptr == DIR_VER_B + 9'h001) begin
                    cur_byte = THR_VERSION[15:8]; // [RULE1]
                end else if (ptr == SECT_LAST) begin
                    cur_byte = 8'h00 - sum; // [RULE19]
                end else if (in_entries && off == 9'h000) begin
                    cur_byte = THR_IDS[thr_idx]; // [RULE2]
                end else if (in_entries && off == 9'h001 && ent < THR_REAL) begin
                    cur_byte = thresh[8*thr_idx +: 8]; // [RULE2] [RULE3]
                end
            end
            K_DIR: begin
                case (ptr)
                    DIR_VER_B:            cur_byte = DIR_VER[7:0]; // [RULE8]
                    DIR_SUM_B:            cur_byte = DIR_SUM[7:0]; // [RULE8]
                    DIR_COMP_B:           cur_byte = DIR_COMP[7:0]; // [RULE8]
                    DIR_EXT_B:            cur_byte = DIR_EXT[7:0]; // [RULE8]
                    DIR_EXT_B + 9'h001:   cur_byte = DIR_EXT[15:8]; // [RULE8]
                    DIR_IDENT_B:          cur_byte = DIR_IDENT;
                    DIR_RSV_B:            cur_byte = DIR_RSV;
                    DIR_A1_B, DIR_A2_B:   cur_byte = DIR_ONE; // [RULE9]
                    default: begin
                        if (ptr >= DIR_SCR_LO_B && ptr <= DIR_SCR_HI_B && !ptr[0]) begin
                            cur_byte = DIR_SCR; // [RULE9]
                        end
                    end
                endcase
            end
            K_ERRSUM: begin
                if (ptr == DIR_VER_B) begin
                    cur_byte = DIR_VER[7:0];
                end else if (ptr == ERR_CMD_B && err_seen) begin
                    cur_byte = err_code; // [RULE11] [RULE12]
                end
            end
            K_SCRATCH: cur_byte = scratch[scr_addr]; // [RULE13]
            K_REMAP: begin
                if (ptr < REMAP_END) begin
                    cur_byte = ptr[0] ? remap_word[15:8] : remap_word[7:0]; // [RULE18]
                end
            end
            default: cur_byte = 8'h00;
        endcase
    end

    // read data mux, captured in setup
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (1'b1)
            sel_count:  next_rdata = {24'h00_0000, sec_count};
            sel_logadr: next_rdata = {24'h00_0000, log_adr};
            sel_cyl:    next_rdata = {16'h0000, cyl_hi, cyl_lo};
            sel_status: next_rdata = {28'h000_0000, defect_predicted, state, irq};
            sel_data:   next_rdata = (state == ST_READ) ? {24'h00_0000, cur_byte} : 32'h0;
            sel_thresh: next_rdata = {8'h00, thresh};
            sel_remap:  next_rdata = {11'h000, remap_sel, remap_mem[remap_sel]};
            sel_err:    next_rdata = {23'h00_0000, err_seen, err_code};
            sel_istat:  next_rdata = {29'h0000_0000, int_stat};
            sel_imask:  next_rdata = {29'h0000_0000, int_mask};
            default:    next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // host-set count, address, thresholds, mask
    always_ff @(posedge mclk) begin
        if (reset) begin
            sec_count <= 8'h00;
            log_adr   <= 8'h00;
            thresh    <= 24'h00_0000;
            int_mask  <= 3'h0;
            remap_sel <= 5'h00;
        end else if (wr_acc) begin
            if (sel_count) sec_count <= pwdata[7:0];
            if (sel_logadr) log_adr <= pwdata[7:0];
            if (sel_thresh) thresh <= pwdata[23:0];
            if (sel_imask) int_mask <= pwdata[2:0];
            if (sel_remap) remap_sel <= pwdata[20:16];
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_acc && sel_remap) begin
            remap_mem[pwdata[20:16]] <= pwdata[15:0];
        end
        if (data_wr && kind == K_SCRATCH) begin
            scratch[scr_addr] <= pwdata[7:0]; // [RULE13]
        end
    end

    // reliability status report
    always_ff @(posedge mclk) begin
        if (reset) begin
            cyl_lo <= 8'h00;
            cyl_hi <= 8'h00;
        end else if (cmd_start && is_status) begin
            cyl_lo <= defect_predicted ? CYL_LO_BAD : CYL_LO_GOOD; // [RULE4] [RULE5]
            cyl_hi <= defect_predicted ? CYL_HI_BAD : CYL_HI_GOOD; // [RULE4] [RULE5]
        end
    end

    // error log command code
    always_ff @(posedge mclk) begin
        if (reset) begin
            err_code <= 8'h00;
            err_seen <= 1'b0;
        end else if (err_event.valid) begin
            err_code <= err_new; // [RULE11] [RULE12]
            err_seen <= 1'b1;
        end
    end

    // transfer control
    always_ff @(posedge mclk) begin
        if (reset) begin
            state    <= ST_IDLE;
            kind     <= K_ZERO;
            xfer_adr <= 8'h00;
            xfer_cnt <= 8'h00;
            sect_idx <= 8'h00;
            ptr      <= 9'h000;
            sum      <= 8'h00;
        end else if (cmd_start && (go_read || go_write)) begin
            state    <= go_read ? ST_READ : ST_WRITE;
            kind     <= next_kind;
            xfer_adr <= log_adr;
            xfer_cnt <= go_rdlog || go_write ? sec_count : 8'h01;
            sect_idx <= 8'h00;
            ptr      <= 9'h000;
            sum      <= 8'h00;
        end else if (advance) begin
            ptr <= ptr + 9'h001;
            sum <= last_byte ? 8'h00 : sum + cur_byte; // [RULE19]
            if (last_byte) begin
                sect_idx <= sect_idx + 8'h01;
            end
            if (xfer_end) begin
                state <= ST_IDLE;
            end
        end
    end

    // interrupt status, set wins over write-one clear
    wire [2:0] int_set = {err_event.valid, reject, done_evt};
    wire [2:0] int_clr = (wr_acc && sel_istat) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge mclk) begin
        if (reset) begin
            int_stat <= 3'h0;
        end else begin
            int_stat <= (int_stat & ~int_clr) | int_set;
        end
    end
    assign irq = |(int_stat & int_mask);

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_status_cmd;
        cmd_start && is_status;
    endsequence
    sequence s_thr_entry;
        state == ST_READ && kind == K_THRESH && in_entries;
    endsequence
    sequence s_last_xfer;
        xfer_end;
    endsequence

    a_thr_version: assert property (state == ST_READ && kind == K_THRESH // [RULE1]
        && ptr == 9'h000 |-> cur_byte == 8'h10)
        else $error("threshold version byte wrong");
    a_thr_reserved: assert property (s_thr_entry ##0 off >= 9'h002 // [RULE2]
        |-> cur_byte == 8'h00)
        else $error("threshold entry reserved byte set");
    a_thr_none: assert property (s_thr_entry ##0 (off == 9'h001 && ent >= THR_REAL) // [RULE3]
        |-> cur_byte == 8'h00)
        else $error("undefined threshold not zero");
    a_status_good: assert property (s_status_cmd ##0 !defect_predicted // [RULE4]
        |=> cyl_lo == 8'h4F && cyl_hi == 8'hC2)
        else $error("good status wrong");
    a_status_bad: assert property (s_status_cmd ##0 defect_predicted // [RULE5]
        |=> cyl_lo == 8'hF4 && cyl_hi == 8'h2C)
        else $error("bad status wrong");
    a_dir_scratch: assert property (state == ST_READ && kind == K_DIR // [RULE9]
        && ptr[8:6] == 3'h4 && !ptr[0] |-> cur_byte == 8'h10)
        else $error("scratch size in directory");
    a_dir_counts: assert property (state == ST_READ && kind == K_DIR // [RULE8]
        && ptr == 9'h004 |-> cur_byte == 8'h33)
        else $error("comprehensive log size wrong");
    a_err_nohost: assert property (err_event.valid && !err_event.processed // [RULE12]
        |=> err_code == 8'hFF && int_stat[INT_ERRLOG])
        else $error("no-host code");
    a_err_unknown: assert property (err_event.valid && err_event.processed // [RULE11]
        && !err_event.identified |=> err_code == 8'hF0)
        else $error("unknown code");
    a_wr_reject: assert property (cmd_start && cmd == CMD_WR_LOG && !is_scr // [RULE15]
        |=> state == ST_IDLE && int_stat[INT_ABORT])
        else $error("write not refused");
    a_remap_rsvd: assert property (state == ST_READ && kind == K_REMAP // [RULE18]
        && ptr >= 9'h040 |-> cur_byte == 8'h00)
        else $error("remap reserved byte set");
    a_checksum: assert property (data_rd && kind == K_THRESH && last_byte // [RULE19]
        |-> 8'(cur_byte + sum) == 8'h00)
        else $error("threshold checksum wrong");
    a_xfer_end: assert property (s_last_xfer // [RULE13]
        |=> state == ST_IDLE && int_stat[INT_DONE] ##1 state == ST_IDLE)
        else $error("transfer did not end");
    a_dir_ext: assert property (state == ST_READ && kind == K_DIR // [RULE8]
        && ptr == 9'h007 |-> cur_byte == 8'h3F)
        else $error("extended log size wrong");
    a_dir_remap: assert property (state == ST_READ && kind == K_DIR // [RULE9]
        && (ptr == 9'h142 || ptr == 9'h144) |-> cur_byte == 8'h01)
        else $error("remap log size wrong");
    a_dir_zero: assert property (state == ST_READ && kind == K_DIR // [RULE10]
        && ptr > 9'h145 |-> cur_byte == 8'h00)
        else $error("directory tail not zero");
    a_scr_store: assert property (data_wr && kind == K_SCRATCH // [RULE13]
        |=> scratch[$past(scr_addr)] == $past(cmd))
        else $error("scratch byte not stored");
    a_log_refuse: assert property (cmd_start && cmd == CMD_RD_LOG && !log_known // [RULE7]
        |=> state == ST_IDLE && int_stat[INT_ABORT])
        else $error("unknown log not refused");
    a_remap_cnt: assert property (cmd_start && cmd == CMD_RD_REMAP && !one_sect // [RULE17]
        |=> state == ST_IDLE && int_stat[INT_ABORT])
        else $error("remap count not refused");
endmodule

/* File: test/slr_host_model.sv */
// Purpose: host that issues health-monitoring commands over APB
// Assumes: requests launched just after a rising edge of mclk
// Notes:   address and data are inverted on release so stale values never match
`timescale 1ns/1ps
module slr_host_model (
    input  wire logic        mclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    import slr_pkg::*;
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= adr;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~adr;
        pwdata  <= ~wd;
        @(posedge mclk);
    endtask
    task automatic issue(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] cnt);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, OFS_COUNT, {24'h0, cnt}, rd, err);
        xfer(1'b1, OFS_LOGADR, {24'h0, adr}, rd, err);
        xfer(1'b1, OFS_CMD, {24'h0, op}, rd, err);
    endtask
endmodule

/* File: test/tb_top.sv */
// Purpose: self-checking bench of the health-monitoring responder
// Assumes: scratch logs shrunk to two sectors
// Notes:   expected sectors are built byte by byte in exp
`timescale 1ns/1ps
module tb_top;
    import slr_pkg::*;
    logic        mclk = 1'b0;
    logic        reset, psel, penable, pwrite, pready, pslverr, defect_predicted, irq, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d, rv;
    logic [23:0] thr;
    slr_err_t    err_event;
    int          fails, samples_checked, sum;
    int          seed = 32'hA213;
    int          exp [1024];
    int          dir_tab [9][2] = '{'{0, 1}, '{2, 1}, '{4, 51}, '{6, 255}, '{7, 63},
                                   '{96, 9}, '{320, 4}, '{322, 1}, '{324, 1}};
    logic [7:0]  ro_tab [5] = '{8'h00, 8'h7F, 8'hA0, 8'hA1, 8'hA2};

    always #10 mclk = ~mclk;
    slr_responder #(.SCR_SECT(2)) u_dut (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .defect_predicted(defect_predicted), .err_event(err_event), .irq(irq));
    slr_host_model u_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic finish_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, want);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        u_host.xfer(1'b0, a, 32'h0, d, e);
        chk(d, want);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_host.xfer(1'b1, a, v, d, e);
    endtask
    task automatic sect(input int n);
        for (int i = 0; i < 512 * n; i++) begin
            rd(OFS_DATA, exp[i]);
        end
    endtask
    task automatic clear_exp;
        foreach (exp[i]) exp[i] = 0;
    endtask

    initial begin
        #600000;
        fails++;
        finish_test();
    end

    initial begin
        reset = 1'b1;
        defect_predicted = 1'b0;
        err_event = '0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        chk(prdata, 32'h0);
        chk({31'h0, pready}, 32'h1);
        // status request masked with no defect, then unmasked in both defect states
        wr(OFS_INT_MASK, 32'h0);
        u_host.issue(CMD_STATUS, 8'h00, 8'h00);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_INT_STAT, 32'h1);
        wr(OFS_INT_STAT, 32'h7);
        wr(OFS_INT_MASK, 32'h7);
        for (int k = 0; k < 2; k++) begin
            defect_predicted <= k[0];
            u_host.issue(CMD_STATUS, 8'h00, 8'h00);
            rd(OFS_CYL, k ? 32'h2CF4 : 32'hC24F);
            chk({31'h0, irq}, 32'h1);
            wr(OFS_INT_STAT, 32'h7);
            chk({31'h0, irq}, 32'h0);
        end
        // threshold sector
        thr = 24'($random(seed));
        wr(OFS_THRESH, {8'h0, thr});
        clear_exp();
        exp[0] = 16;
        for (int k = 0; k < 17; k++) begin
            exp[2 + 12 * k] = THR_IDS[k];
            exp[3 + 12 * k] = (k < 3) ? thr[8 * k +: 8] : 0;
        end
        sum = 0;
        for (int i = 0; i < 511; i++) begin
            sum += exp[i];
        end
        exp[511] = (256 - sum % 256) % 256;
        u_host.issue(CMD_RD_THRESH, 8'h00, 8'h01);
        rd(OFS_STATUS, 32'hA);
        sect(1);
        rd(OFS_INT_STAT, 32'h1);
        wr(OFS_INT_STAT, 32'h7);
        // directory and reserved log
        clear_exp();
        foreach (dir_tab[i]) exp[dir_tab[i][0]] = dir_tab[i][1];
        for (int i = 256; i < 320; i += 2) begin
            exp[i] = 16;
        end
        u_host.issue(CMD_RD_LOG, LOG_DIR, 8'h01);
        sect(1);
        clear_exp();
        u_host.issue(CMD_RD_LOG, LOG_RSVD, 8'h01);
        sect(1);
        // scratch log written then read back, full-width random write data
        u_host.issue(CMD_WR_LOG, LOG_SCR_LO, 8'h02);
        for (int i = 0; i < 1024; i++) begin
            rv = $random(seed);
            exp[i] = rv[7:0];
            wr(OFS_DATA, rv);
        end
        wr(OFS_INT_STAT, 32'h7);
        foreach (ro_tab[i]) begin
            u_host.issue(CMD_WR_LOG, ro_tab[i], 8'h01);
            rd(OFS_INT_STAT, 32'h2);
            wr(OFS_INT_STAT, 32'h7);
        end
        u_host.issue(CMD_RD_LOG, 8'h7F, 8'h01);
        rd(OFS_INT_STAT, 32'h2);
        wr(OFS_INT_STAT, 32'h7);
        u_host.issue(CMD_RD_REMAP, 8'h00, 8'h02);
        rd(OFS_INT_STAT, 32'h2);
        wr(OFS_INT_STAT, 32'h7);
        u_host.issue(CMD_RD_LOG, LOG_SCR_LO, 8'h02);
        sect(2);
        // remap table through its command and through the log
        clear_exp();
        for (int i = 0; i < 32; i++) begin
            rv = $random(seed);
            exp[2 * i] = rv[7:0];
            exp[2 * i + 1] = rv[15:8];
            wr(OFS_REMAP, {11'h0, i[4:0], rv[15:0]});
        end
        u_host.issue(CMD_RD_REMAP, 8'h00, 8'h01);
        sect(1);
        u_host.issue(CMD_RD_LOG, LOG_REMAP, 8'h01);
        sect(1);
        // error events and the error-logged interrupt
        wr(OFS_INT_STAT, 32'h7);
        wr(OFS_INT_MASK, 32'h4);
        for (int k = 0; k < 3; k++) begin
            rv = $random(seed);
            err_event <= '{valid: 1'b1, processed: (k > 0), identified: (k > 1), cmd: rv[7:0]};
            @(posedge mclk);
            err_event <= '0;
            @(posedge mclk);
            chk({31'h0, irq}, 32'h1);
            rd(OFS_ERRCODE, {23'h0, 1'b1, k == 0 ? 8'hFF : k == 1 ? 8'hF0 : rv[7:0]});
            wr(OFS_INT_STAT, 32'h4);
            chk({31'h0, irq}, 32'h0);
        end
        clear_exp();
        exp[0] = 1;
        exp[2] = rv[7:0];
        u_host.issue(CMD_RD_LOG, LOG_ERRSUM, 8'h01);
        sect(1);
        // unmapped address
        u_host.xfer(1'b0, 8'h2C, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        finish_test();
    end
endmodule
